/* src/bsd_top.sv */
// Holds the boot strap decoder: samples strap pins at reset release and decodes them.
// Assumes strap pins are board-pulled levels and resetn comes from the reset pin logic.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Reset low holds; release starts sampling.
// - Supply strap low 3.3V, high 1.8V.
// - Boot 00 download, 10/11 flash boot.
// - Debug strap 0 silent, 1 prints.
// - Timing 00 fall/fall, 01 fall/rise.
// - Timing 10 rising input, falling output.
// - Timing 11 rise/rise; upper bit is debug.
module bsd_top (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic strap_vsel,
	input wire logic [1:0] strap_boot,
	input wire logic strap_dbg,
	input wire logic strap_tim_lo,
	output logic cfg_valid,
	output logic flash_vsel_1v8,
	output logic boot_download,
	output logic boot_flash,
	output logic boot_undef,
	output logic primary_serial_port_dbg_en,
	output logic sdio_in_rise,
	output logic sdio_out_rise,
	output logic [1:0] sdio_tim_code
);
	import bsd_pkg::*;

	////////////////////////////////////////////////////////////////////////////////

	function automatic bsd_boot_t bsd_boot_dec(input logic [1:0] code);
		case (code)
			BSD_BOOT_DOWNLOAD: bsd_boot_dec = BSD_MODE_DOWNLOAD;
			BSD_BOOT_FLASH_A: bsd_boot_dec = BSD_MODE_FLASH;
			BSD_BOOT_FLASH_B: bsd_boot_dec = BSD_MODE_FLASH;
			default: bsd_boot_dec = BSD_MODE_UNDEF;
		endcase
	endfunction

	// Falling input edge for 00 and 01, rising for 10 and 11.
	function automatic logic bsd_in_rise_dec(input logic [1:0] code);
		case (code)
			BSD_TIM_FF: bsd_in_rise_dec = 1'b0;
			BSD_TIM_FR: bsd_in_rise_dec = 1'b0;
			BSD_TIM_RF: bsd_in_rise_dec = 1'b1;
			BSD_TIM_RR: bsd_in_rise_dec = 1'b1;
			default: bsd_in_rise_dec = 1'b1;
		endcase
	endfunction

	// Rising output edge for 01 and 11, falling for 00 and 10.
	function automatic logic bsd_out_rise_dec(input logic [1:0] code);
		case (code)
			BSD_TIM_FF: bsd_out_rise_dec = 1'b0;
			BSD_TIM_FR: bsd_out_rise_dec = 1'b1;
			BSD_TIM_RF: bsd_out_rise_dec = 1'b0;
			BSD_TIM_RR: bsd_out_rise_dec = 1'b1;
			default: bsd_out_rise_dec = 1'b1;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	// Every output is held in a flop, so the pins of the device never see
	// decode glitches while the settings stand.
	typedef struct packed {
		bsd_state_t st;
		logic fill;
		logic vsel_1v8;
		logic boot_dl;
		logic boot_fl;
		logic boot_undef;
		logic dbg_en;
		logic [1:0] tim;
		logic in_rise;
		logic out_rise;
		logic valid;
	} bsd_top_state_t;

	logic [BSD_STRAP_W-1:0] pins_raw;
	logic [BSD_STRAP_W-1:0] pins_s;
	bsd_top_state_t s_q;
	bsd_top_state_t s_d;

	bsd_boot_t dec_boot;
	logic dec_vsel_1v8;
	logic dec_boot_dl;
	logic dec_boot_fl;
	logic dec_boot_undef;
	logic dec_dbg_en;
	logic [1:0] dec_tim;
	logic dec_in_rise;
	logic dec_out_rise;

	////////////////////////////////////////////////////////////////////////////////

	// Pins cross into the clock domain before anything decodes them.
	assign pins_raw = {strap_tim_lo, strap_dbg, strap_boot, strap_vsel};

	bsd_sync u_sync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.pin_in(pins_raw),
		.pin_sync(pins_s)
	);

	////////////////////////////////////////////////////////////////////////////////

	// Decodes the synchronised levels; only the capture state uses the result.
	always_comb begin
		dec_vsel_1v8 = (pins_s[BSD_POS_VSEL] == BSD_VSEL_1V8);
		dec_boot = bsd_boot_dec(pins_s[BSD_POS_BOOT_HI:BSD_POS_BOOT_LO]);
		dec_boot_dl = (dec_boot == BSD_MODE_DOWNLOAD);
		dec_boot_fl = (dec_boot == BSD_MODE_FLASH);
		// The reserved code is flagged rather than guessed at.
		dec_boot_undef = (dec_boot == BSD_MODE_UNDEF);
		dec_dbg_en = pins_s[BSD_POS_DBG];
		// The debug strap doubles as the upper bit of the timing code.
		dec_tim = {pins_s[BSD_POS_DBG], pins_s[BSD_POS_TIM_LO]};
		dec_in_rise = bsd_in_rise_dec(dec_tim);
		dec_out_rise = bsd_out_rise_dec(dec_tim);
	end

	////////////////////////////////////////////////////////////////////////////////

	// The synchroniser is held at the default levels during reset, so the level
	// present at the release edge needs two more edges to reach its output.
	// Capture waits one extra cycle in the reset state for that reason.
	always_comb begin
		s_d = s_q;
		case (s_q.st)
			BSD_ST_RESET: begin
				s_d.fill = 1'b1;
				if (s_q.fill) begin
					s_d.st = BSD_ST_SAMPLE;
				end else begin
					s_d.st = BSD_ST_RESET;
				end
			end
			BSD_ST_SAMPLE: begin
				s_d.st = BSD_ST_HOLD;
				s_d.vsel_1v8 = dec_vsel_1v8;
				s_d.boot_dl = dec_boot_dl;
				s_d.boot_fl = dec_boot_fl;
				s_d.boot_undef = dec_boot_undef;
				s_d.dbg_en = dec_dbg_en;
				s_d.tim = dec_tim;
				s_d.in_rise = dec_in_rise;
				s_d.out_rise = dec_out_rise;
				s_d.valid = 1'b1;
			end
			BSD_ST_HOLD: begin
				// Later pin activity is ignored until the next reset.
				s_d.st = BSD_ST_HOLD;
			end
			default: begin
				s_d.st = BSD_ST_RESET;
				s_d.fill = 1'b0;
				s_d.valid = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////

	// Reset shows the decode of the board default levels.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_q.st <= BSD_ST_RESET;
			s_q.fill <= 1'b0;
			s_q.vsel_1v8 <= (BSD_VSEL_RST == BSD_VSEL_1V8);
			s_q.boot_dl <= (BSD_BOOT_RST == BSD_BOOT_DOWNLOAD);
			s_q.boot_fl <= (BSD_BOOT_RST == BSD_BOOT_FLASH_A) ||
				(BSD_BOOT_RST == BSD_BOOT_FLASH_B);
			s_q.boot_undef <= (BSD_BOOT_RST == BSD_BOOT_RESERVED);
			s_q.dbg_en <= BSD_DBG_RST;
			s_q.tim <= BSD_TIM_RST;
			s_q.in_rise <= BSD_TIM_RST[BSD_TIM_HI_POS];
			s_q.out_rise <= BSD_TIM_RST[BSD_TIM_HI_POS-1];
			s_q.valid <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	assign cfg_valid = s_q.valid;

	assign flash_vsel_1v8 = s_q.vsel_1v8;

	assign boot_download = s_q.boot_dl;

	assign boot_flash = s_q.boot_fl;

	assign boot_undef = s_q.boot_undef;

	assign primary_serial_port_dbg_en = s_q.dbg_en;

	assign sdio_tim_code = s_q.tim;

	assign sdio_in_rise = s_q.in_rise;

	assign sdio_out_rise = s_q.out_rise;

endmodule

/* pkg/bsd_pkg.sv */
// Holds the constants and types shared by the boot strap decoder.
// Assumes the strap levels arrive as pins from the board, outside the clock domain.
package bsd_pkg;

	// Flash supply strap: low picks 3.3 V, high (pull-up default) picks 1.8 V.
	localparam logic BSD_VSEL_3V3 = 1'b0;
	localparam logic BSD_VSEL_1V8 = 1'b1;
	localparam logic BSD_VSEL_RST = BSD_VSEL_1V8;

	// Boot mode strap codes.
	localparam logic [1:0] BSD_BOOT_DOWNLOAD = 2'h0;
	localparam logic [1:0] BSD_BOOT_RESERVED = 2'h1;
	localparam logic [1:0] BSD_BOOT_FLASH_A = 2'h2;
	localparam logic [1:0] BSD_BOOT_FLASH_B = 2'h3;
	localparam logic [1:0] BSD_BOOT_RST = BSD_BOOT_FLASH_A;

	// Debug strap: zero is silent, one (pull-up default) prints.
	localparam logic BSD_DBG_RST = 1'b1;

	// Slave timing codes, upper bit shared with the debug strap.
	localparam logic [1:0] BSD_TIM_FF = 2'h0;
	localparam logic [1:0] BSD_TIM_FR = 2'h1;
	localparam logic [1:0] BSD_TIM_RF = 2'h2;
	localparam logic [1:0] BSD_TIM_RR = 2'h3;
	localparam logic [1:0] BSD_TIM_RST = BSD_TIM_RR;
	localparam int BSD_TIM_HI_POS = 1;

	// Strap bus layout as seen by the synchroniser.
	localparam int BSD_STRAP_W = 5;
	localparam int BSD_POS_VSEL = 0;
	localparam int BSD_POS_BOOT_LO = 1;
	localparam int BSD_POS_BOOT_HI = 2;
	localparam int BSD_POS_DBG = 3;
	localparam int BSD_POS_TIM_LO = 4;
	localparam logic [BSD_STRAP_W-1:0] BSD_SYNC_RST = 5'h1_d;

	typedef enum logic [2:0] {
		BSD_ST_RESET = 3'h1,
		BSD_ST_SAMPLE = 3'h2,
		BSD_ST_HOLD = 3'h4
	} bsd_state_t;

	typedef enum logic [1:0] {
		BSD_MODE_DOWNLOAD = 2'h0,
		BSD_MODE_FLASH = 2'h1,
		BSD_MODE_UNDEF = 2'h2
	} bsd_boot_t;

endpackage

/* src/bsd_sync.sv */
// Holds a two-flop synchroniser for a bus of independent strap levels.
// Assumes each bit is a quasi-static level; bits are not coherent with each other.
`timescale 1ns/10ps
module bsd_sync (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [bsd_pkg::BSD_STRAP_W-1:0] pin_in,
	output logic [bsd_pkg::BSD_STRAP_W-1:0] pin_sync
);
	import bsd_pkg::*;

	typedef struct packed {
		logic [BSD_STRAP_W-1:0] meta;
		logic [BSD_STRAP_W-1:0] sync;
	} bsd_sync_state_t;

	bsd_sync_state_t s_q;
	bsd_sync_state_t s_d;

	always_comb begin
		s_d.meta = pin_in;
		s_d.sync = s_q.meta;
	end

	// Reset values match the board defaults so no false code appears early.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_q <= '{meta: BSD_SYNC_RST, sync: BSD_SYNC_RST};
		end else begin
			s_q <= s_d;
		end
	end

	assign pin_sync = s_q.sync;
endmodule

/* bench/bsd_assertions.sv */
// Port checker for the strap decoder.
// Assumes the bench holds straps steady across capture.
`timescale 1ns/10ps
module bsd_chk (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic strap_vsel,
	input wire logic [1:0] strap_boot,
	input wire logic strap_dbg,
	input wire logic strap_tim_lo,
	input wire logic cfg_valid,
	input wire logic flash_vsel_1v8,
	input wire logic boot_download,
	input wire logic boot_flash,
	input wire logic boot_undef,
	input wire logic primary_serial_port_dbg_en,
	input wire logic sdio_in_rise,
	input wire logic sdio_out_rise,
	input wire logic [1:0] sdio_tim_code
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	property p_rst; disable iff (1'b0) !resetn |=> !cfg_valid; endproperty
	a_rst: assert property (p_rst) else $error("valid in reset");
	property p_go; $rose(resetn) |-> ##[1:4] cfg_valid; endproperty
	a_go: assert property (p_go) else $error("no capture");
	property p_hold; cfg_valid |=> $stable({flash_vsel_1v8, boot_flash, sdio_tim_code}); endproperty
	a_hold: assert property (p_hold) else $error("decode moved");
	property p_vs; $rose(cfg_valid) |-> flash_vsel_1v8 == strap_vsel; endproperty
	a_vs: assert property (p_vs) else $error("bad supply");
	property p_bt; $rose(cfg_valid) |-> boot_download == (strap_boot == 2'b00); endproperty
	a_bt: assert property (p_bt) else $error("bad boot");
	property p_dbg; $rose(cfg_valid) |-> primary_serial_port_dbg_en == strap_dbg; endproperty
	a_dbg: assert property (p_dbg) else $error("bad debug");
	property p_tim; cfg_valid |-> {sdio_in_rise, sdio_out_rise} == sdio_tim_code; endproperty
	a_tim: assert property (p_tim) else $error("bad edges");
	property p_sh; cfg_valid |-> sdio_tim_code[1] == primary_serial_port_dbg_en; endproperty
	a_sh: assert property (p_sh) else $error("shared bit");
	cover property ($rose(cfg_valid));
	cover property (cfg_valid && sdio_tim_code == 2'b10);
	cover property (cfg_valid && boot_download);
endmodule
bind bsd_top bsd_chk u_chk (.*);

/* bench/bsd_board.sv */
// Board model: strap levels and the reset driver.
// Assumes the bench picks levels and reset timing.
`timescale 1ns/10ps
module bsd_board (
	input wire logic clk_sys,
	input wire logic rst_req,
	input wire logic [4:0] lvl,
	output logic resetn,
	output logic strap_vsel,
	output logic [1:0] strap_boot,
	output logic strap_dbg,
	output logic strap_tim_lo
);
	initial resetn = 1'b0;
	// Pulled pins are modelled as firm levels, so none floats.
	assign {strap_tim_lo, strap_dbg, strap_vsel} = {lvl[4], lvl[3], lvl[0]};
	assign strap_boot = (lvl[2:1] == 2'b01) ? 2'b00 : lvl[2:1];
	// Reset moves just after a rising edge, so it never races the bench's writes.
	always @(posedge clk_sys) begin
		resetn <= !rst_req;
	end
endmodule

/* bench/testbench.sv */
// Boots the decoder under eight strap sets and checks the decode.
// Assumes the board model drives reset and straps.
`timescale 1ns/10ps
module testbench;
	logic clk_sys = 1'b1;
	logic rst_req = 1'b1;
	logic [4:0] lvl = 5'h1d;
	int mismatches = 0;
	int n_compared = 0;
	logic resetn, strap_vsel, strap_dbg, strap_tim_lo, cfg_valid, flash_vsel_1v8;
	logic boot_download, boot_flash, boot_undef, primary_serial_port_dbg_en;
	logic sdio_in_rise, sdio_out_rise;
	logic [1:0] strap_boot, sdio_tim_code;
	bsd_board board (.*);
	bsd_top dut (.*);
	always #10 clk_sys = ~clk_sys;
	task chk(input logic [1:0] got, input logic [1:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %0t: got %b expected %b", $time, got, exp);
		end
	endtask
	task end_sim;
		$display("Compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task boot(input logic [4:0] p);
		int k;
		rst_req = 1'b1;
		lvl = p;
		repeat (3) @(negedge clk_sys);
		chk({1'b0, cfg_valid}, 2'b00);
		rst_req = 1'b0;
		for (k = 0; k < 10 && cfg_valid !== 1'b1; k++) @(negedge clk_sys);
		if (k == 10) begin
			mismatches++;
			$display("Error %0t: no capture", $time);
			end_sim();
		end
		@(negedge clk_sys);
		lvl = ~p;
		repeat (3) @(negedge clk_sys);
		chk({flash_vsel_1v8, primary_serial_port_dbg_en}, {p[0], p[3]});
		chk({boot_download, boot_flash}, {p[2:1] == 2'b00, p[2]});
		chk(sdio_tim_code, {p[3], p[4]});
		chk({sdio_in_rise, sdio_out_rise}, {p[3], p[4]});
		chk({boot_undef, cfg_valid}, 2'b01);
	endtask
	initial begin
		for (int i = 0; i < 8; i++) begin
			boot({i[0], i[1], i[2], i[2] & i[0], i[1] ^ i[0]});
		end
		end_sim();
	end
endmodule
